// file: verilog/transfer_mode_control.sv
// Functional notes
// - issue parameters come from the transfer-mode register and the data_present input, never from packet bytes.
// - bit 15 clear gives full duplex, set gives two-lane half duplex.
// - bit 14 set waits for end-busy packet, then sets transfer complete.
// - end-busy packet carrying an error sets the end-busy error flag.
// - end-busy error also sets summary error, together with transfer complete.
// - bit 8 set suppresses command complete regardless of its enable.
// - bit 7 set checks responses and raises the response packet fault.
// - exactly two formats, memory and io function, chosen by bit 6.
// - memory format errors: range, address, block length, write protect, locked.
// - io format errors: command crc, general, function number, range.
// - bit 5 picks block mode when clear, byte mode when set.
// - bit 4 picks card-to-host read when clear, host-to-card write when set.
// - bit 1 ends data at block count terminal in block mode; bit 0 enables dma.
`timescale 1ns/1ns
module transfer_mode_control (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // command issue from the trigger logic
    input wire logic cmd_issue,
    input wire logic data_present,
    // link receive side
    input wire logic resp_valid,
    input wire logic [31:0] resp_status,
    input wire logic end_busy_packet_valid,
    input wire logic end_busy_packet_error,
    input wire logic blk_count_zero,
    // issue control towards the link
    output transfer_mode_pkg::issue_params_t issue_params,
    output logic cmd_active,
    output logic xfer_stop,
    // interrupt
    output logic irq
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic [15:0] tmc;
    logic [transfer_mode_pkg::INT_BITS-1:0] int_status;
    logic [transfer_mode_pkg::INT_BITS-1:0] int_mask;
    logic [transfer_mode_pkg::INT_BITS-1:0] int_set;
    logic [transfer_mode_pkg::INT_BITS-1:0] int_clr;
    transfer_mode_pkg::seq_state_t state;
    transfer_mode_pkg::seq_state_t next_state;
    logic apb_access;
    logic apb_write;
    logic mapped;
    logic issue_take;
    logic resp_take;
    logic end_busy_packet_take;
    logic resp_err;
    logic [31:0] read_word;

    // ************************************************************
    // apb decode
    // ************************************************************
    // one wait state: pready rises in the second access cycle, so read data and
    // the error answer can both come straight from flops
    assign apb_access = psel & penable & pready;
    assign apb_write = apb_access & pwrite;
    assign mapped = (paddr == transfer_mode_pkg::ADDR_TRANSFER_MODE)
        | (paddr == transfer_mode_pkg::ADDR_INT_STATUS)
        | (paddr == transfer_mode_pkg::ADDR_INT_MASK);

    // read mux, narrower registers sit in the low bits
    always_comb begin
        read_word = 32'h0000_0000;
        case (paddr)
            transfer_mode_pkg::ADDR_TRANSFER_MODE: begin
                read_word = {16'h0000, tmc};
            end
            transfer_mode_pkg::ADDR_INT_STATUS: begin
                read_word = {27'h000_0000, int_status};
            end
            transfer_mode_pkg::ADDR_INT_MASK: begin
                read_word = {27'h000_0000, int_mask};
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= read_word;
            end
        end
    end

    // ************************************************************
    // transfer-mode control register
    // ************************************************************
    // reserved bits masked on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmc <= transfer_mode_pkg::TMC_RESET;
        end else if (apb_write && paddr == transfer_mode_pkg::ADDR_TRANSFER_MODE) begin
            tmc <= pwdata[15:0] & transfer_mode_pkg::TMC_RW_MASK;
        end
    end

    // ************************************************************
    // command sequencer
    // ************************************************************
    // an issue while a command is still running is dropped; the trigger logic
    // must wait for cmd_active to fall
    assign issue_take = cmd_issue & (state == transfer_mode_pkg::ST_IDLE);
    assign resp_take = resp_valid & (state == transfer_mode_pkg::ST_RESP);
    assign end_busy_packet_take = end_busy_packet_valid & (state == transfer_mode_pkg::ST_BUSY);

    // after the response, wait for the end-busy packet when asked
    always_comb begin
        next_state = state;
        case (state)
            transfer_mode_pkg::ST_IDLE: begin
                if (issue_take) begin
                    next_state = transfer_mode_pkg::ST_RESP;
                end
            end
            transfer_mode_pkg::ST_RESP: begin
                if (resp_take) begin
                    next_state = issue_params.busy_wait ? transfer_mode_pkg::ST_BUSY : transfer_mode_pkg::ST_IDLE;
                end
            end
            transfer_mode_pkg::ST_BUSY: begin
                if (end_busy_packet_take) begin
                    next_state = transfer_mode_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = transfer_mode_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= transfer_mode_pkg::ST_IDLE;
            cmd_active <= 1'b0;
        end else begin
            state <= next_state;
            cmd_active <= next_state != transfer_mode_pkg::ST_IDLE;
        end
    end

    // snapshot the register at issue, packet bytes are never parsed
    // lane mode, block or byte unit, direction, count and dma
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            issue_params <= '0;
        end else if (issue_take) begin
            issue_params.half_duplex <= tmc[transfer_mode_pkg::BIT_HALF_DUPLEX];
            issue_params.busy_wait <= tmc[transfer_mode_pkg::BIT_BUSY_WAIT];
            issue_params.resp_int_dis <= tmc[transfer_mode_pkg::BIT_RESP_INT_DIS];
            issue_params.resp_chk_en <= tmc[transfer_mode_pkg::BIT_RESP_CHK_EN];
            issue_params.resp_fmt_io <= tmc[transfer_mode_pkg::BIT_RESP_FMT];
            issue_params.byte_mode <= tmc[transfer_mode_pkg::BIT_BYTE_MODE];
            issue_params.write_dir <= tmc[transfer_mode_pkg::BIT_WRITE_DIR];
            issue_params.blk_cnt_en <= tmc[transfer_mode_pkg::BIT_BLK_CNT_EN];
            issue_params.dma_en <= tmc[transfer_mode_pkg::BIT_DMA_EN];
            issue_params.data_present <= data_present;
        end
    end

    // stop the data phase at block count terminal, block mode only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_stop <= 1'b0;
        end else begin
            xfer_stop <= cmd_active & issue_params.data_present & issue_params.blk_cnt_en
                & ~issue_params.byte_mode & blk_count_zero & ~xfer_stop;
        end
    end

    // ************************************************************
    // response checking
    // ************************************************************
    // format chosen from the snapshot taken at issue
    resp_error_check u_check (
        .fmt_io(issue_params.resp_fmt_io),
        .status_word(resp_status),
        .error_found(resp_err)
    );

    // ************************************************************
    // interrupt status, mask and output
    // ************************************************************
    always_comb begin
        int_set = transfer_mode_pkg::INT_RESET;
        // command complete not raised while response interrupt disabled
        int_set[transfer_mode_pkg::INT_CMD_COMPLETE] = resp_take & ~issue_params.resp_int_dis;
        // hardware check flags a faulty response
        int_set[transfer_mode_pkg::INT_RESP_FAULT] = resp_take & issue_params.resp_chk_en & resp_err;
        // end of busy marks transfer complete
        int_set[transfer_mode_pkg::INT_XFER_COMPLETE] = end_busy_packet_take;
        int_set[transfer_mode_pkg::INT_END_BUSY_ERR] = end_busy_packet_take & end_busy_packet_error;
        // summary error with transfer complete on an end-busy error, or with the response fault
        int_set[transfer_mode_pkg::INT_ERROR_SUMMARY] = (end_busy_packet_take & end_busy_packet_error)
            | (resp_take & issue_params.resp_chk_en & resp_err);
    end

    assign int_clr = (apb_write && paddr == transfer_mode_pkg::ADDR_INT_STATUS)
        ? pwdata[transfer_mode_pkg::INT_BITS-1:0] : transfer_mode_pkg::INT_RESET;

    // write one to clear; a set in the same cycle wins so no event is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= transfer_mode_pkg::INT_RESET;
        end else begin
            int_status <= (int_status & ~int_clr) | int_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= transfer_mode_pkg::INT_RESET;
        end else if (apb_write && paddr == transfer_mode_pkg::ADDR_INT_MASK) begin
            int_mask <= pwdata[transfer_mode_pkg::INT_BITS-1:0];
        end
    end

    // level interrupt, one cycle behind status so the output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_params_snapshot: assert property (
        @(posedge pclk) disable iff (!presetn)
        issue_take |=> issue_params.half_duplex == $past(tmc[transfer_mode_pkg::BIT_HALF_DUPLEX])
            && issue_params.byte_mode == $past(tmc[transfer_mode_pkg::BIT_BYTE_MODE])
            && issue_params.write_dir == $past(tmc[transfer_mode_pkg::BIT_WRITE_DIR])
            && issue_params.dma_en == $past(tmc[transfer_mode_pkg::BIT_DMA_EN])
    ) else $error("issue parameters differ from register at issue");

    a_busy_wait_entry: assert property (
        @(posedge pclk) disable iff (!presetn)
        resp_take && issue_params.busy_wait |=> state == transfer_mode_pkg::ST_BUSY && cmd_active
    ) else $error("busy wait not entered after response");

    a_busy_done_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        end_busy_packet_take |=> int_status[transfer_mode_pkg::INT_XFER_COMPLETE] && !cmd_active
    ) else $error("end of busy did not set transfer complete");

    a_busy_error_pair: assert property (
        @(posedge pclk) disable iff (!presetn)
        end_busy_packet_take && end_busy_packet_error |=> int_status[transfer_mode_pkg::INT_END_BUSY_ERR]
            && int_status[transfer_mode_pkg::INT_ERROR_SUMMARY]
            && int_status[transfer_mode_pkg::INT_XFER_COMPLETE]
    ) else $error("end-busy error flags not set together");

    a_busy_clean_end: assert property (
        @(posedge pclk) disable iff (!presetn)
        end_busy_packet_take && !end_busy_packet_error |=> !$rose(int_status[transfer_mode_pkg::INT_END_BUSY_ERR])
    ) else $error("end-busy error set without an error");

    a_resp_int_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        resp_take && issue_params.resp_int_dis |=> !$rose(int_status[transfer_mode_pkg::INT_CMD_COMPLETE])
    ) else $error("command complete raised while disabled");

    a_resp_int_on: assert property (
        @(posedge pclk) disable iff (!presetn)
        resp_take && !issue_params.resp_int_dis |=> int_status[transfer_mode_pkg::INT_CMD_COMPLETE]
    ) else $error("command complete missing");

    a_resp_fault_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        resp_take && issue_params.resp_chk_en && resp_err |=> int_status[transfer_mode_pkg::INT_RESP_FAULT]
    ) else $error("response fault not flagged");

    a_resp_no_check: assert property (
        @(posedge pclk) disable iff (!presetn)
        resp_take && !issue_params.resp_chk_en |=> !$rose(int_status[transfer_mode_pkg::INT_RESP_FAULT])
    ) else $error("response fault flagged with checking off");

    a_mem_fmt_decode: assert property (
        @(posedge pclk) disable iff (!presetn)
        !issue_params.resp_fmt_io && resp_status[transfer_mode_pkg::MEM_CARD_LOCKED_FLAG] |-> resp_err
    ) else $error("memory format error bit missed");

    a_io_fmt_decode: assert property (
        @(posedge pclk) disable iff (!presetn)
        issue_params.resp_fmt_io && resp_status[transfer_mode_pkg::IO_COMMAND_CRC_FAULT] |-> resp_err
    ) else $error("io format error bit missed");

    a_reserved_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tmc & ~transfer_mode_pkg::TMC_RW_MASK) == 16'h0000
    ) else $error("reserved transfer-mode bits not zero");

    a_stop_terminal: assert property (
        @(posedge pclk) disable iff (!presetn)
        xfer_stop |-> $past(issue_params.blk_cnt_en) && !$past(issue_params.byte_mode) && $past(blk_count_zero)
    ) else $error("data stop without block count terminal");

    a_issue_refused: assert property (
        @(posedge pclk) disable iff (!presetn)
        cmd_active |=> $stable(issue_params)
    ) else $error("issue parameters changed during a command");

    a_busy_flags_joint: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(int_status[transfer_mode_pkg::INT_END_BUSY_ERR])
            |-> int_status[transfer_mode_pkg::INT_XFER_COMPLETE]
            && int_status[transfer_mode_pkg::INT_ERROR_SUMMARY]
    ) else $error("end-busy error without its companion flags");

    a_io_fmt_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        issue_params.resp_fmt_io && !resp_status[transfer_mode_pkg::IO_COMMAND_CRC_FAULT]
            && !resp_status[transfer_mode_pkg::IO_GENERAL_FAULT]
            && !resp_status[transfer_mode_pkg::IO_FUNCTION_NUMBER_FAULT]
            && !resp_status[transfer_mode_pkg::IO_ARGUMENT_RANGE_FAULT] |-> !resp_err
    ) else $error("io format flagged a bit outside its set");

    a_mem_fmt_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        !issue_params.resp_fmt_io && !resp_status[transfer_mode_pkg::MEM_ARGUMENT_RANGE_FAULT]
            && !resp_status[transfer_mode_pkg::MEM_ADDRESS_FAULT]
            && !resp_status[transfer_mode_pkg::MEM_BLOCK_LENGTH_FAULT]
            && !resp_status[transfer_mode_pkg::MEM_WRITE_PROTECT_FAULT]
            && !resp_status[transfer_mode_pkg::MEM_CARD_LOCKED_FLAG] |-> !resp_err
    ) else $error("memory format flagged a bit outside its set");

endmodule : transfer_mode_control

// file: verilog/transfer_mode_pkg.sv
package transfer_mode_pkg;

    // ************************************************************
    // register map (byte addresses on the apb bus)
    // ************************************************************
    localparam logic [11:0] ADDR_TRANSFER_MODE = 12'h09c;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h100;
    localparam logic [11:0] ADDR_INT_MASK = 12'h104;

    // ************************************************************
    // transfer-mode control fields
    // ************************************************************
    localparam int BIT_HALF_DUPLEX = 15;
    localparam int BIT_BUSY_WAIT = 14;
    localparam int BIT_RESP_INT_DIS = 8;
    localparam int BIT_RESP_CHK_EN = 7;
    localparam int BIT_RESP_FMT = 6;
    localparam int BIT_BYTE_MODE = 5;
    localparam int BIT_WRITE_DIR = 4;
    localparam int BIT_BLK_CNT_EN = 1;
    localparam int BIT_DMA_EN = 0;
    // writable bits; 13..9 and 3..2 stay zero
    localparam logic [15:0] TMC_RW_MASK = 16'hc1f3;
    localparam logic [15:0] TMC_RESET = 16'h0000;

    // ************************************************************
    // interrupt status / mask layout
    // ************************************************************
    localparam int INT_BITS = 5;
    localparam int INT_CMD_COMPLETE = 0;
    localparam int INT_XFER_COMPLETE = 1;
    localparam int INT_END_BUSY_ERR = 2;
    localparam int INT_RESP_FAULT = 3;
    localparam int INT_ERROR_SUMMARY = 4;
    localparam logic [INT_BITS-1:0] INT_RESET = 5'h00;

    // ************************************************************
    // response error bits, memory and io function formats
    // ************************************************************
    localparam int MEM_ARGUMENT_RANGE_FAULT = 31;
    localparam int MEM_ADDRESS_FAULT = 30;
    localparam int MEM_BLOCK_LENGTH_FAULT = 29;
    localparam int MEM_WRITE_PROTECT_FAULT = 26;
    localparam int MEM_CARD_LOCKED_FLAG = 25;
    localparam int IO_COMMAND_CRC_FAULT = 7;
    localparam int IO_GENERAL_FAULT = 3;
    localparam int IO_FUNCTION_NUMBER_FAULT = 1;
    localparam int IO_ARGUMENT_RANGE_FAULT = 0;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic half_duplex;
        logic busy_wait;
        logic resp_int_dis;
        logic resp_chk_en;
        logic resp_fmt_io;
        logic byte_mode;
        logic write_dir;
        logic blk_cnt_en;
        logic dma_en;
        logic data_present;
    } issue_params_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESP = 2'b01,
        ST_BUSY = 2'b10
    } seq_state_t;

endpackage : transfer_mode_pkg

// file: verilog/resp_error_check.sv
`timescale 1ns/1ns
module resp_error_check (
    // selection
    input wire logic fmt_io,
    // response status word
    input wire logic [31:0] status_word,
    // result
    output logic error_found
);
    // **********************************************************
    // error decode for the two supported response formats
    // **********************************************************
    logic mem_err;
    logic io_err;

    assign mem_err = status_word[transfer_mode_pkg::MEM_ARGUMENT_RANGE_FAULT]
        | status_word[transfer_mode_pkg::MEM_ADDRESS_FAULT]
        | status_word[transfer_mode_pkg::MEM_BLOCK_LENGTH_FAULT]
        | status_word[transfer_mode_pkg::MEM_WRITE_PROTECT_FAULT]
        | status_word[transfer_mode_pkg::MEM_CARD_LOCKED_FLAG];
    assign io_err = status_word[transfer_mode_pkg::IO_COMMAND_CRC_FAULT]
        | status_word[transfer_mode_pkg::IO_GENERAL_FAULT]
        | status_word[transfer_mode_pkg::IO_FUNCTION_NUMBER_FAULT]
        | status_word[transfer_mode_pkg::IO_ARGUMENT_RANGE_FAULT];
    // select memory when clear, io when set
    assign error_found = fmt_io ? io_err : mem_err;

endmodule : resp_error_check

// file: test/card_link_model.sv
`timescale 1ns/1ns
// ************************************************************
// card at the far end of the lane link
// ************************************************************
module card_link_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // issue side of the controller
    input wire logic cmd_active,
    input wire transfer_mode_pkg::issue_params_t issue_params,
    // scenario controls
    input wire logic [1:0] resp_gap,
    input wire logic [31:0] resp_word,
    input wire logic end_busy_packet_fail,
    // link receive lines
    output logic resp_valid,
    output logic [31:0] resp_status,
    output logic end_busy_packet_valid,
    output logic end_busy_packet_error
);
    // one response per command; idle lines carry the inverse so stale data never matches
    initial begin
        resp_valid = 1'b0;
        resp_status = 32'h0;
        end_busy_packet_valid = 1'b0;
        end_busy_packet_error = 1'b0;
        forever begin
            @(posedge pclk iff (cmd_active && presetn));
            repeat (resp_gap) @(posedge pclk);
            resp_valid <= 1'b1;
            resp_status <= resp_word;
            @(posedge pclk);
            resp_valid <= 1'b0;
            resp_status <= ~resp_word;
            if (issue_params.busy_wait) begin
                repeat (resp_gap) @(posedge pclk);
                end_busy_packet_valid <= 1'b1;
                end_busy_packet_error <= end_busy_packet_fail;
                @(posedge pclk);
                end_busy_packet_valid <= 1'b0;
                end_busy_packet_error <= ~end_busy_packet_fail;
            end
            @(posedge pclk iff !cmd_active);
        end
    end
endmodule : card_link_model

// file: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    // ************************************************************
    // signals
    // ************************************************************
    localparam logic [11:0] A_TMC = transfer_mode_pkg::ADDR_TRANSFER_MODE;
    localparam logic [11:0] A_ST = transfer_mode_pkg::ADDR_INT_STATUS;
    localparam logic [11:0] A_MSK = transfer_mode_pkg::ADDR_INT_MASK;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic cmd_issue, data_present, blk_count_zero, cmd_active, xfer_stop;
    logic resp_valid, end_busy_packet_valid, end_busy_packet_error, end_busy_packet_fail;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, resp_status, resp_word, r;
    logic [31:0] seed = 32'h43;
    logic [1:0] resp_gap;
    logic [33:0] note;
    logic [33:0] exp_q[$];
    int bits[9] = '{31, 30, 29, 26, 25, 7, 3, 1, 0};
    int errors, tests_run, cycles, stops;
    transfer_mode_pkg::issue_params_t issue_params;

    transfer_mode_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmd_issue, .data_present, .resp_valid, .resp_status, .end_busy_packet_valid,
        .end_busy_packet_error, .blk_count_zero, .issue_params, .cmd_active, .xfer_stop, .irq);
    card_link_model u_card (.pclk, .presetn, .cmd_active, .issue_params, .resp_gap, .resp_word,
        .end_busy_packet_fail, .resp_valid, .resp_status, .end_busy_packet_valid, .end_busy_packet_error);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    // e holds {pslverr, prdata}; read data is only compared on reads
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back({~wr, e});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_for(input logic lvl);
        int n;
        n = 0;
        while (cmd_active !== lvl && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, cmd_active}, {31'h0, lvl});
    endtask : wait_for

    // status expected from the mode bits: bit4 summary, bit3 fault, bit2 busy error, bit1 done, bit0 cmd
    function automatic logic [31:0] exp_status(input logic [15:0] t, input logic [31:0] w, input logic ef);
        logic f;
        f = t[7] && (((t[6] ? 32'h0000008b : 32'he6000000) & w) != 32'h0);
        return {27'h0, f || (t[14] && ef), f, t[14] && ef, t[14], !t[8]};
    endfunction : exp_status

    // dz is {block count at terminal, data present}
    task automatic run_cmd(input logic [15:0] t, input logic [1:0] dz, input logic [31:0] w, input logic ef);
        int n0;
        apb(1'b1, A_TMC, {16'h0, t}, 33'h0);
        apb(1'b1, A_ST, 32'h1f, 33'h0);
        r = rnd();
        resp_word <= w;
        end_busy_packet_fail <= ef;
        resp_gap <= r[1:0];
        blk_count_zero <= dz[1];
        n0 = stops;
        cmd_issue <= 1'b1;
        data_present <= dz[0];
        @(posedge pclk);
        cmd_issue <= 1'b0;
        wait_for(1'b1);
        chk({22'h0, issue_params}, {22'h0, t[15:14], t[8:4], t[1:0], dz[0]});
        wait_for(1'b0);
        apb(1'b0, A_ST, 32'h0, {1'b0, exp_status(t, w, ef)});
        chk({31'h0, stops != n0}, {31'h0, dz[0] & t[1] & ~t[5] & dz[1]});
    endtask : run_cmd

    // ************************************************************
    // monitor and timeout
    // ************************************************************
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (xfer_stop === 1'b1)
            stops <= stops + 1;
        if (psel && penable && pready === 1'b1) begin
            note = exp_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, note[32]});
            if (note[33])
                chk(prdata, note[31:0]);
        end
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {presetn, psel, penable, pwrite, cmd_issue, data_present, blk_count_zero, end_busy_packet_fail} = 8'h0;
        {paddr, pwdata, resp_word, resp_gap} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, reserved bits, unmapped place
        apb(1'b0, A_TMC, 32'h0, {17'h0, transfer_mode_pkg::TMC_RESET});
        apb(1'b0, A_ST, 32'h0, 33'h0);
        apb(1'b1, A_TMC, 32'hffffffff, 33'h0);
        apb(1'b0, A_TMC, 32'h0, {17'h0, transfer_mode_pkg::TMC_RW_MASK});
        apb(1'b1, 12'h0a0, 32'h1, {1'b1, 32'h0});
        apb(1'b0, 12'h0a0, 32'h0, {1'b1, 32'h0});
        // each error bit in both formats
        for (int f = 0; f < 2; f++)
            foreach (bits[i])
                run_cmd(16'h0180 | 16'(f << 6), 2'b00, 32'h1 << bits[i], 1'b0);
        // busy wait with and without error, stop at terminal
        run_cmd(16'h4000, 2'b01, 32'h0, 1'b1);
        run_cmd(16'h4002, 2'b11, 32'h0, 1'b0);
        // random modes with hardware response checking among them
        repeat (20) begin
            r = rnd();
            run_cmd(r[15:0], r[17:16], rnd() & rnd(), r[18]);
        end
        // interrupt: raise, mask, clear
        run_cmd(16'h0000, 2'b00, 32'h0, 1'b0);
        apb(1'b1, A_MSK, 32'h0, 33'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, A_MSK, 32'h1, 33'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, A_MSK, 32'h0, 33'h1);
        apb(1'b1, A_ST, 32'h1, 33'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wrap_up();
    end
endmodule : tb_top
